// *** rtl/scp_regs.svh ***
// Purpose: Offsets, field positions, reset values and counts of the prescaler
// Assumes: Byte addresses are four times the register index
// Notes: Definitions only
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_IDX_DIVSEL 8'h61
`define SCP_IDX_TRIM 8'h62
`define SCP_ADDR_DIVSEL 12'h184
`define SCP_ADDR_TRIM 12'h188
`define SCP_UNLOCK_BIT 7
`define SCP_CODE_MSB 3
`define SCP_CODE_RESET 4'h0
`define SCP_CODE_DIV8 4'h3
`define SCP_CODE_MAX 4'h8
`define SCP_UNLOCK_CYCLES 3'h4
`define SCP_TRIM_DEFAULT 8'h80

`endif

// *** rtl/scp_pkg.sv ***
// Purpose: Types of the system clock prescaler
// Assumes: Nothing
// Notes: Constants live in scp_regs.svh
package scp_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } scp_apb_req_t;

  typedef enum logic [1:0] {
    SCP_RUN,
    SCP_WAIT_OLD,
    SCP_WAIT_NEW
  } scp_sw_state_t;
endpackage : scp_pkg

// *** rtl/scp_ripple_div.sv ***
// Purpose: Free running divide counter on the undivided clock
// Assumes: One clock; count state is internal only
// Notes: Terminal pulse per power of two
`timescale 1ns/1ps
`default_nettype none
module scp_ripple_div #(
  parameter int STAGES = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Terminal count per stage, one-cycle pulses; tick[0] held high
  output logic [STAGES:0] tick
);
  logic [STAGES-1:0] count;

  // Counter runs on the undivided source clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick[0] = 1'b1;
  genvar g;
  generate
    for (g = 1; g <= STAGES; g++) begin : g_tick
      assign tick[g] = &count[g-1:0];
    end
  endgenerate
endmodule : scp_ripple_div
`default_nettype wire

// *** rtl/scp_apb_slave.sv ***
// Purpose: APB slave front end, zero wait state
// Assumes: Aligned 32-bit words
// Notes: Presents a one-cycle access strobe and the request fields
`timescale 1ns/1ps
`default_nettype none
module scp_apb_slave
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  // Decoded access
  output logic access,
  output scp_apb_req_t req
);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign access = psel & penable;
  assign req.paddr = paddr;
  assign req.pwrite = pwrite;
  assign req.pwdata = pwdata;
endmodule : scp_apb_slave
`default_nettype wire

// *** rtl/scp_prescaler.sv ***
// Purpose: System clock prescaler with protected select and oscillator trim
// Assumes: 100 MHz core_clk is the undivided source clock
// Notes: Divided clock given as enable sys_clk_en, one-cycle pulses except held high at code 0
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.svh"

module scp_prescaler
  import scp_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = `SCP_TRIM_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Fuse and factory value, static pins
  input wire logic startup_divide_by_eight_fuse,
  input wire logic [7:0] factory_trim_value,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Clock enables and trim
  output logic sys_clk_en,
  output logic [3:0] active_division_code,
  output logic [7:0] rc_oscillator_trim
);
  localparam int STAGES = 8;

  scp_apb_req_t req;
  logic access;
  logic pready_c;
  logic pslverr_c;
  logic [STAGES:0] tick;
  logic fuse_s1, fuse_s2;
  logic [7:0] ftrim_s1, ftrim_s2;
  logic [1:0] strap_count;
  logic strap_done;
  logic divider_change_unlock;
  logic [2:0] unlock_count;
  logic [3:0] division_code;
  logic [3:0] run_code;
  logic [3:0] pend_code;
  logic pend;
  logic [1:0] edges_left;
  scp_sw_state_t sw_state;
  logic en_c;
  logic wr_div, wr_trim, rd_c;
  logic code_wr;
  logic [31:0] next_prdata;

  function automatic logic [STAGES:0] code_mask(input logic [3:0] c);
    code_mask = '0;
    if (c <= `SCP_CODE_MAX) begin
      code_mask[c] = 1'b1;
    end
  endfunction : code_mask

  // Start-up code picked by the fuse
  function automatic logic [3:0] strap_code(input logic fuse);
    strap_code = fuse ? `SCP_CODE_DIV8 : `SCP_CODE_RESET;
  endfunction : strap_code

  // Unlock word: unlock bit one, bits 6:0 zero, bits 31:8 ignored
  function automatic logic is_unlock_word(input logic [31:0] d);
    is_unlock_word = (d[7:0] == 8'h80);
  endfunction : is_unlock_word

  // Code word: unlock bit written as zero
  function automatic logic is_code_word(input logic [31:0] d);
    is_code_word = ~d[`SCP_UNLOCK_BIT];
  endfunction : is_code_word

  scp_apb_slave u_apb (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready_c),
    .pslverr(pslverr_c),
    .access(access),
    .req(req)
  );

  scp_ripple_div #(.STAGES(STAGES)) u_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  assign wr_div = access & req.pwrite & (req.paddr == `SCP_ADDR_DIVSEL);
  assign wr_trim = access & req.pwrite & (req.paddr == `SCP_ADDR_TRIM);
  assign rd_c = psel & ~penable & ~pwrite;
  assign code_wr = wr_div & divider_change_unlock & is_code_word(req.pwdata);

  // Enable from ticks; reserved codes hold the last legal rate
  assign en_c = |(tick & code_mask(run_code));

  // Fuse through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_s1 <= 1'b0;
      fuse_s2 <= 1'b0;
    end else begin
      fuse_s1 <= startup_divide_by_eight_fuse;
      fuse_s2 <= fuse_s1;
    end
  end

  // Factory trim through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ftrim_s1 <= '0;
      ftrim_s2 <= '0;
    end else begin
      ftrim_s1 <= factory_trim_value;
      ftrim_s2 <= ftrim_s1;
    end
  end

  // Edges since release; second flops hold the pins from the third
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_count <= '0;
    end else if (strap_count != 2'h3) begin
      strap_count <= strap_count + 2'h1;
    end
  end

  // Straps are caught up to the third edge, then left alone
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
    end else if (strap_count == 2'h2) begin
      strap_done <= 1'b1;
    end
  end

  // Unlock window; a rewrite while open falls through untouched
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divider_change_unlock <= 1'b0;
    end else if (divider_change_unlock) begin
      if (wr_div && is_code_word(req.pwdata)) begin
        divider_change_unlock <= 1'b0;
      end else if (sys_clk_en &&
                   unlock_count == `SCP_UNLOCK_CYCLES - 3'h1) begin
        divider_change_unlock <= 1'b0;
      end
    end else if (wr_div && is_unlock_word(req.pwdata)) begin
      divider_change_unlock <= 1'b1;
    end
  end

  // Divided cycles since the window opened
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_count <= '0;
    end else if (!divider_change_unlock) begin
      unlock_count <= '0;
    end else if (sys_clk_en) begin
      unlock_count <= unlock_count + 3'h1;
    end
  end

  // Division code register, read back as written
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      division_code <= `SCP_CODE_RESET;
    end else if (!strap_done) begin
      division_code <= strap_code(fuse_s2);
    end else if (code_wr) begin
      division_code <= req.pwdata[`SCP_CODE_MSB:0];
    end
  end

  // Code waiting for the switch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_code <= `SCP_CODE_RESET;
    end else if (!strap_done) begin
      pend_code <= strap_code(fuse_s2);
    end else if (code_wr) begin
      pend_code <= req.pwdata[`SCP_CODE_MSB:0];
    end
  end

  // A new code wins over the clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 1'b0;
    end else if (!strap_done || code_wr) begin
      pend <= 1'b1;
    end else if (sw_state == SCP_WAIT_OLD) begin
      pend <= 1'b0;
    end
  end

  // Switch on an old edge, then let two new edges pass
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_state <= SCP_RUN;
    end else begin
      unique case (sw_state)
        SCP_RUN: begin
          if (pend) begin
            sw_state <= SCP_WAIT_OLD;
          end
        end
        SCP_WAIT_OLD: begin
          if (en_c) begin
            sw_state <= SCP_WAIT_NEW;
          end
        end
        SCP_WAIT_NEW: begin
          if (en_c && edges_left == 2'h1) begin
            sw_state <= SCP_RUN;
          end
        end
      endcase
    end
  end

  // Rate in force; reserved codes keep the last legal one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_code <= `SCP_CODE_RESET;
    end else if (sw_state == SCP_WAIT_OLD && en_c &&
                 pend_code <= `SCP_CODE_MAX) begin
      run_code <= pend_code;
    end
  end

  // New-rate edges still to pass before another switch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      edges_left <= '0;
    end else if (sw_state == SCP_WAIT_OLD && en_c) begin
      edges_left <= 2'h2;
    end else if (sw_state == SCP_WAIT_NEW && en_c) begin
      edges_left <= edges_left - 2'h1;
    end
  end

  // Trim register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_oscillator_trim <= FACTORY_TRIM;
    end else if (!strap_done) begin
      rc_oscillator_trim <= ftrim_s2;
    end else if (wr_trim) begin
      rc_oscillator_trim <= req.pwdata[7:0];
    end
  end

  // Read data, divider register bits 6:4 zero
  always_comb begin
    next_prdata = '0;
    if (paddr == `SCP_ADDR_DIVSEL) begin
      next_prdata[`SCP_UNLOCK_BIT] = divider_change_unlock;
      next_prdata[`SCP_CODE_MSB:0] = division_code;
    end else if (paddr == `SCP_ADDR_TRIM) begin
      next_prdata[7:0] = rc_oscillator_trim;
    end
  end

  // Read data, caught in the setup phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (rd_c) begin
      prdata <= next_prdata;
    end
  end

  // Divided clock enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= en_c;
    end
  end

  // Code in force, in step with the enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_division_code <= `SCP_CODE_RESET;
    end else begin
      active_division_code <= run_code;
    end
  end

  // Ready in the first access cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_c & psel & ~penable;
    end
  end

  // No error response
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_c;
    end
  end
endmodule : scp_prescaler
`default_nettype wire

// *** testbench/scp_prescaler_chk.sv ***
// Purpose: Port checker for the system clock prescaler
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Bound to every scp_prescaler instance
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.svh"
module scp_prescaler_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  // Outputs
  input wire logic sys_clk_en,
  input wire logic [3:0] active_division_code,
  input wire logic [7:0] rc_oscillator_trim
);
  logic [8:0] gap;
  logic [3:0] last_code;
  logic seen;
  logic [3:0] settle;
  logic trim_wr;
  logic [7:0] wr_byte;
  logic [3:0] lo;
  logic [3:0] hi;
  assign trim_wr = psel && penable && pready && pwrite
    && paddr == `SCP_ADDR_TRIM;
  assign wr_byte = pwdata[7:0];
  assign lo = (last_code < active_division_code) ? last_code :
    active_division_code;
  assign hi = (last_code < active_division_code) ? active_division_code :
    last_code;
  // Cycles since the last divided clock pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap <= 9'h000;
      seen <= 1'b0;
      last_code <= 4'h0;
    end else if (sys_clk_en) begin
      gap <= 9'h000;
      seen <= 1'b1;
      last_code <= active_division_code;
    end else if (gap != 9'h1FF) begin
      gap <= gap + 9'h001;
    end
  end
  // Time since reset release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle <= 4'h0;
    end else if (settle != 4'hF) begin
      settle <= settle + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_rsv;
    psel && penable && !pwrite && paddr == `SCP_ADDR_DIVSEL
      |-> prdata[6:4] == 3'h0;
  endproperty
  property p_legal;
    sys_clk_en |-> active_division_code <= 4'h8;
  endproperty
  property p_nofast;
    sys_clk_en && seen |-> {1'b0, gap} + 10'h001 >= (10'h001 << lo);
  endproperty
  property p_slow;
    sys_clk_en && seen |-> {1'b0, gap} + 10'h001 <= (10'h001 << hi);
  endproperty
  property p_range;
    trim_wr |=> rc_oscillator_trim[7] == $past(wr_byte[7]);
  endproperty
  property p_fine;
    trim_wr |=> rc_oscillator_trim[6:0] == $past(wr_byte[6:0]);
  endproperty
  property p_hold;
    settle == 4'hF && !$past(trim_wr) |-> $stable(rc_oscillator_trim);
  endproperty
  property p_trim_rd;
    psel && penable && !pwrite && paddr == `SCP_ADDR_TRIM
      |-> prdata[7:0] == rc_oscillator_trim;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved divider bits read nonzero");
  a_legal: assert property (p_legal)
    else $error("division code in force is reserved");
  a_nofast: assert property (p_nofast)
    else $error("divided period shorter than both settings");
  a_slow: assert property (p_slow)
    else $error("divided period longer than the setting");
  a_range: assert property (p_range)
    else $error("trim range bit not as written");
  a_fine: assert property (p_fine)
    else $error("trim fine field not as written");
  a_hold: assert property (p_hold)
    else $error("trim changed without a write");
  a_trim_rd: assert property (p_trim_rd)
    else $error("trim readback differs from trim output");
  c_div256: cover property (sys_clk_en && active_division_code == 4'h8);
  c_trim_wr: cover property (trim_wr);
  c_div_rd: cover property (psel && penable && !pwrite
    && paddr == `SCP_ADDR_DIVSEL);
endmodule : scp_prescaler_chk
bind scp_prescaler scp_prescaler_chk scp_prescaler_chk_inst (
  .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .sys_clk_en, .active_division_code,
  .rc_oscillator_trim);
`default_nettype wire

// *** testbench/system_clock_prescaler_test.sv ***
// Purpose: Self-checking bench for the system clock prescaler
// Assumes: APB answers by pready; seed fixed
// Notes: Read data checked by a monitor against a queue
`timescale 1ns/1ps
`default_nettype none
`include "scp_regs.svh"
module system_clock_prescaler_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic startup_divide_by_eight_fuse = 1'b1;
  logic [7:0] factory_trim_value = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic pslverr;
  logic sys_clk_en;
  logic [31:0] prdata;
  logic [3:0] active_division_code;
  logic [7:0] rc_oscillator_trim;
  logic [31:0] exp_q[$];
  logic [7:0] tv;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int gap;
  always #5 core_clk = ~core_clk;
  scp_prescaler scp_prescaler_inst (.core_clk, .reset_n,
    .startup_divide_by_eight_fuse, .factory_trim_value, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .sys_clk_en,
    .active_division_code, .rc_oscillator_trim);
  task automatic test_done;
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pulses(input int n);
    repeat (n) do @(posedge core_clk); while (sys_clk_en !== 1'b1);
  endtask : pulses
  task automatic setc(input logic [3:0] c);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    apb(1'b1, `SCP_ADDR_DIVSEL, {28'h0, c});
  endtask : setc
  // Read data monitor
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk(prdata, exp_q.pop_front());
    end
    if (psel && penable && pready === 1'b1) begin
      chk({31'h0, pslverr}, 32'h0);
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    void'($urandom(80964));
    factory_trim_value = 8'($urandom);
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`SCP_ADDR_DIVSEL, 32'h3);
    rd(`SCP_ADDR_TRIM, {24'h0, factory_trim_value});
    rd(12'h0F0, 32'h0);
    for (int c = 0; c <= 8; c++) begin
      setc(c[3:0]);
      rd(`SCP_ADDR_DIVSEL, c);
      pulses(3);
      pulses(1);
      gap = 0;
      do begin
        @(posedge core_clk);
        gap++;
      end while (sys_clk_en !== 1'b1);
      chk(gap, 1 << c);
    end
    setc(4'h9);
    rd(`SCP_ADDR_DIVSEL, 32'h9);
    chk(active_division_code, 4'h8);
    setc(4'h1);
    pulses(3);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h81);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h2);
    rd(`SCP_ADDR_DIVSEL, 32'h1);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    rd(`SCP_ADDR_DIVSEL, 32'h81);
    repeat (12) @(posedge core_clk);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h2);
    rd(`SCP_ADDR_DIVSEL, 32'h1);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    repeat (2) @(posedge core_clk);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    repeat (4) @(posedge core_clk);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h2);
    rd(`SCP_ADDR_DIVSEL, 32'h1);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h80);
    apb(1'b1, `SCP_ADDR_DIVSEL, 32'h2);
    rd(`SCP_ADDR_DIVSEL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      tv = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
      apb(1'b1, `SCP_ADDR_TRIM, {24'h0, tv});
      rd(`SCP_ADDR_TRIM, {24'h0, tv});
      chk(rc_oscillator_trim, tv);
    end
    startup_divide_by_eight_fuse <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(`SCP_ADDR_DIVSEL, 32'h0);
    rd(`SCP_ADDR_TRIM, {24'h0, factory_trim_value});
    test_done();
  end
endmodule : system_clock_prescaler_test
`default_nettype wire
